// [mmb_pkg.sv]
// Constants and types for the program-counter, return-stack and data-banking block
`default_nettype none
package mmb_pkg;
  // ==========================================================
  // Program side
  localparam int PC_W = 10;
  localparam int PCH_W = 2;
  localparam int SHORT_W = 8;
  localparam logic [PC_W-1:0] RESET_VEC = 10'h000;
  localparam logic [PC_W-1:0] SWI_VEC = 10'h001;
  localparam logic [PC_W-1:0] HWI_VEC = 10'h008;
  localparam logic [PC_W-1:0] RSVD_LO = 10'h3fe;
  localparam logic [PC_W-1:0] ROLL_LO = 10'h00e;
  localparam logic [PC_W-1:0] ROLL_HI = 10'h00f;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_W = 3;
  // ==========================================================
  // Data side
  localparam int DATA_W = 8;
  localparam int LOC_W = 7;
  localparam int BANK_MSB = 7;
  localparam int BANK_LSB = 6;
  localparam int FLAG_W = 3;
  localparam int AUX_AW = 5;
  localparam int GPR_DEPTH = 64;
  localparam int GPR_AW = 6;
  localparam logic [LOC_W-1:0] ADDR_INDIRECT_DATA_PORT = 7'h00;
  localparam logic [LOC_W-1:0] ADDR_TIMER = 7'h01;
  localparam logic [LOC_W-1:0] ADDR_PCL = 7'h02;
  localparam logic [LOC_W-1:0] ADDR_STATUS = 7'h03;
  localparam logic [LOC_W-1:0] ADDR_FSR = 7'h04;
  localparam logic [LOC_W-1:0] ADDR_PROGRAM_COUNTER_HIGH_BUFFER = 7'h0a;
  localparam logic [LOC_W-1:0] GPR_LO = 7'h20;
  localparam logic [LOC_W-1:0] GPR_HI = 7'h5f;
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;
  localparam logic [DATA_W-1:0] FSR_RST = 8'h00;
  localparam logic [DATA_W-1:0] PROGRAM_COUNTER_HIGH_BUFFER_RST = 8'h00;
  localparam int ACCESS_LAT = 2;
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    OP_STEP, OP_SJMP, OP_SCALL, OP_LJMP, OP_LONG_CALL_INSTR,
    OP_RET, OP_RETURN_WITH_LITERAL_INSTR, OP_RETURN_FROM_INTERRUPT_INSTR, OP_SWI, OP_HWI
  } mmb_op_e;
  typedef enum logic [1:0] {PG_R, PG_A, PG_B} mmb_page_e;
  typedef enum logic [1:0] {SRC_SFR, SRC_GPR, SRC_AUX} mmb_src_e;
  typedef enum logic [2:0] {
    RG_NONE, RG_INDIRECT_DATA_PORT, RG_TIMER, RG_PCL, RG_STATUS, RG_FSR, RG_PROGRAM_COUNTER_HIGH_BUFFER, RG_GPR
  } mmb_region_e;
endpackage
`default_nettype wire

// [mmb_if.sv]
// Carriers between the banking core and its stack and storage modules
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Return stack link
interface mmb_stack_if import mmb_pkg::*; ;
  logic push;
  logic pop;
  logic [PC_W-1:0] push_data;
  logic [PC_W-1:0] top;
  modport ctrl(output push, output pop, output push_data, input top);
  modport store(input push, input pop, input push_data, output top);
endinterface

// ==========================================================
// General storage link
interface mmb_ram_if import mmb_pkg::*; ;
  logic we;
  logic [GPR_AW-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport ctrl(output we, output addr, output wdata, input rdata);
  modport store(input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// [mmb_stack.sv]
// Eight-level hardware return stack with registered top entry
`timescale 1ns/1ps
`default_nettype none
module mmb_stack import mmb_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  mmb_stack_if.store stk
);
  typedef struct packed {
    logic [STACK_DEPTH-1:0][PC_W-1:0] ent;
    logic [STACK_PTR_W-1:0] ptr;
    logic [PC_W-1:0] top;
  } mmb_stack_s;

  mmb_stack_s state_reg;
  mmb_stack_s state_next;

  // Circular buffer; overflow silently overwrites the oldest level
  always_comb begin
    state_next = state_reg;
    if (stk.push) begin
      state_next.ent[state_reg.ptr] = stk.push_data;
      state_next.ptr = state_reg.ptr + STACK_PTR_W'(1);
      state_next.top = stk.push_data;
    end else if (stk.pop) begin
      state_next.ptr = state_reg.ptr - STACK_PTR_W'(1);
      state_next.top = state_reg.ent[state_reg.ptr - STACK_PTR_W'(2)];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  assign stk.top = state_reg.top;

  // ==========================================================
  // Checks
  a_push_then_pop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (clk_en_i && stk.push) ##1 (clk_en_i && stk.push) ##1 (clk_en_i && stk.pop)
    |=> stk.top == $past(stk.push_data, 3))
    else $error("stack top wrong after two pushes and a pop");
endmodule
`default_nettype wire

// [mmb_gpr_ram.sv]
// General storage block shared by all four banks, registered read
`timescale 1ns/1ps
`default_nettype none
module mmb_gpr_ram import mmb_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  mmb_ram_if.store ram
);
  typedef struct packed {
    logic [GPR_DEPTH-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] rdata;
  } mmb_ram_s;

  mmb_ram_s state_reg;
  mmb_ram_s state_next;

  // Read returns the old word on a same-cycle write
  always_comb begin
    state_next = state_reg;
    state_next.rdata = state_reg.mem[ram.addr];
    if (ram.we) begin
      state_next.mem[ram.addr] = ram.wdata;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  assign ram.rdata = state_reg.rdata;

  // ==========================================================
  // Checks
  a_write_read_back: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (clk_en_i && ram.we) ##1 (clk_en_i && ram.addr == $past(ram.addr) && !ram.we)
    |=> ram.rdata == $past(ram.wdata, 2))
    else $error("storage did not return the written word");
endmodule
`default_nettype wire

// [mmb_core.sv]
// Program counter, vectors, return-stack control and banked data decode
`timescale 1ns/1ps
`default_nettype none
module mmb_core import mmb_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic op_valid_i,
  input wire mmb_op_e op_kind_i,
  input wire logic [PC_W-1:0] op_target_i,
  input wire logic rolling_release_i,
  input wire logic dat_req_i,
  input wire logic dat_wr_i,
  input wire mmb_page_e dat_page_i,
  input wire logic [LOC_W-1:0] dat_addr_i,
  input wire logic [DATA_W-1:0] dat_wdata_i,
  input wire logic alu_flags_we_i,
  input wire logic [FLAG_W-1:0] alu_flags_i,
  input wire logic [DATA_W-1:0] timer_count_i,
  input wire logic [DATA_W-1:0] aux_rdata_i,
  output logic [PC_W-1:0] pc_o,
  output logic [DATA_W-1:0] status_o,
  output logic [1:0] bank_sel_o,
  output logic dat_ack_o,
  output logic [DATA_W-1:0] dat_rdata_o,
  output logic timer_wr_o,
  output logic [DATA_W-1:0] timer_wdata_o,
  output logic aux_req_o,
  output logic aux_page_b_o,
  output logic aux_wr_o,
  output logic [AUX_AW-1:0] aux_addr_o,
  output logic [DATA_W-1:0] aux_wdata_o,
  output logic reserved_fetch_o,
  output logic rolling_zone_o
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] file_select_pointer;
    logic [DATA_W-1:0] program_counter_high_buffer;
    logic roll_lock;
    logic reserved_fetch;
    logic rolling_zone;
    logic any_change;
    logic s1_valid;
    mmb_src_e s1_src;
    logic [DATA_W-1:0] s1_data;
    logic ack;
    logic [DATA_W-1:0] rdata;
    logic timer_wr;
    logic [DATA_W-1:0] timer_wdata;
    logic aux_req;
    logic aux_page_b;
    logic aux_wr;
    logic [AUX_AW-1:0] aux_addr;
    logic [DATA_W-1:0] aux_wdata;
  } mmb_core_s;

  localparam mmb_core_s CORE_RST = '{
    pc: RESET_VEC, status: STATUS_RST, file_select_pointer: FSR_RST, program_counter_high_buffer: PROGRAM_COUNTER_HIGH_BUFFER_RST,
    roll_lock: 1'b1, s1_src: SRC_SFR, default: '0
  };

  mmb_core_s state_reg;
  mmb_core_s state_next;

  mmb_stack_if stk_if();
  mmb_ram_if ram_if();

  // ==========================================================
  // Special-register decode, shared by direct and indirect paths
  function automatic mmb_region_e mmb_region(input logic [LOC_W-1:0] loc);
    mmb_region_e r;
    r = RG_NONE;
    if (loc == ADDR_INDIRECT_DATA_PORT) begin
      r = RG_INDIRECT_DATA_PORT;
    end else if (loc == ADDR_TIMER) begin
      r = RG_TIMER;
    end else if (loc == ADDR_PCL) begin
      r = RG_PCL;
    end else if (loc == ADDR_STATUS) begin
      r = RG_STATUS;
    end else if (loc == ADDR_FSR) begin
      r = RG_FSR;
    end else if (loc == ADDR_PROGRAM_COUNTER_HIGH_BUFFER) begin
      r = RG_PROGRAM_COUNTER_HIGH_BUFFER;
    end else if (loc >= GPR_LO && loc <= GPR_HI) begin
      r = RG_GPR;
    end
    return r;
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [LOC_W-1:0] loc;
    mmb_region_e rgn;
    logic r_acc;
    logic r_wr;
    logic pcl_wr;
    logic [PC_W-1:0] pc_inc;
    logic [DATA_W-1:0] sfr_rd;
    loc = dat_addr_i;
    rgn = RG_NONE;
    r_acc = dat_req_i && dat_page_i == PG_R;
    r_wr = r_acc && dat_wr_i;
    pcl_wr = 1'b0;
    pc_inc = state_reg.pc + PC_W'(1);
    sfr_rd = '0;
    state_next = state_reg;
    stk_if.push = 1'b0;
    stk_if.pop = 1'b0;
    stk_if.push_data = pc_inc;
    ram_if.we = 1'b0;
    ram_if.wdata = dat_wdata_i;

    // Pulses last one enabled cycle
    state_next.timer_wr = 1'b0;
    state_next.aux_req = 1'b0;

    // Location: the indirect port redirects through the pointer; banks never change
    // the physical target because all four banks alias onto bank 0 storage
    if (mmb_region(dat_addr_i) == RG_INDIRECT_DATA_PORT) begin
      loc = state_reg.file_select_pointer[LOC_W-1:0];
    end else begin
      loc = dat_addr_i;
    end
    rgn = mmb_region(loc);
    ram_if.addr = GPR_AW'(loc - GPR_LO);

    // Register read sample; indirect through the port itself reads zero
    unique case (rgn)
      RG_TIMER: sfr_rd = timer_count_i;
      RG_PCL: sfr_rd = state_reg.pc[SHORT_W-1:0];
      RG_STATUS: sfr_rd = state_reg.status;
      RG_FSR: sfr_rd = state_reg.file_select_pointer;
      RG_PROGRAM_COUNTER_HIGH_BUFFER: sfr_rd = state_reg.program_counter_high_buffer;
      RG_NONE, RG_INDIRECT_DATA_PORT, RG_GPR: sfr_rd = '0;
    endcase

    // Flags from arithmetic first, so a data write to status wins
    if (alu_flags_we_i) begin
      state_next.status[FLAG_W-1:0] = alu_flags_i;
    end

    // Register writes; unassigned and self-indirect targets drop the write
    if (r_wr) begin
      unique case (rgn)
        RG_TIMER: begin
          state_next.timer_wr = 1'b1;
          state_next.timer_wdata = dat_wdata_i;
        end
        RG_PCL: pcl_wr = 1'b1;
        RG_STATUS: state_next.status = dat_wdata_i;
        RG_FSR: state_next.file_select_pointer = dat_wdata_i;
        RG_PROGRAM_COUNTER_HIGH_BUFFER: state_next.program_counter_high_buffer = dat_wdata_i;
        RG_GPR: ram_if.we = clk_en_i;
        RG_NONE, RG_INDIRECT_DATA_PORT: state_next.s1_data = state_reg.s1_data;
      endcase
    end

    // Read pipeline stage one
    state_next.s1_valid = dat_req_i;
    state_next.s1_data = sfr_rd;
    state_next.s1_src = (rgn == RG_GPR) ? SRC_GPR : SRC_SFR;

    // Auxiliary pages bypass the bank bits and the main decode
    if (dat_req_i && dat_page_i != PG_R) begin
      state_next.aux_req = 1'b1;
      state_next.aux_page_b = dat_page_i == PG_B;
      state_next.aux_wr = dat_wr_i;
      state_next.aux_addr = dat_addr_i[AUX_AW-1:0];
      state_next.aux_wdata = dat_wdata_i;
      state_next.s1_src = SRC_AUX;
    end

    // Read pipeline stage two, answer to the execution unit
    state_next.ack = state_reg.s1_valid;
    unique case (state_reg.s1_src)
      SRC_GPR: state_next.rdata = ram_if.rdata;
      SRC_AUX: state_next.rdata = aux_rdata_i;
      SRC_SFR: state_next.rdata = state_reg.s1_data;
    endcase

    // Program flow
    if (op_valid_i) begin
      unique case (op_kind_i)
        OP_STEP: state_next.pc = pc_inc;
        OP_SJMP: begin
          state_next.pc = {state_reg.pc[PC_W-1:SHORT_W], op_target_i[SHORT_W-1:0]};
        end
        OP_SCALL: begin
          state_next.pc = {state_reg.pc[PC_W-1:SHORT_W], op_target_i[SHORT_W-1:0]};
          stk_if.push = clk_en_i;
        end
        OP_LJMP: state_next.pc = op_target_i;
        OP_LONG_CALL_INSTR: begin
          state_next.pc = op_target_i;
          stk_if.push = clk_en_i;
        end
        OP_RET, OP_RETURN_WITH_LITERAL_INSTR, OP_RETURN_FROM_INTERRUPT_INSTR: begin
          state_next.pc = stk_if.top;
          stk_if.pop = clk_en_i;
        end
        OP_SWI: begin
          state_next.pc = SWI_VEC;
          stk_if.push = clk_en_i;
          stk_if.push_data = state_reg.pc;
        end
        OP_HWI: begin
          state_next.pc = HWI_VEC;
          stk_if.push = clk_en_i;
          stk_if.push_data = state_reg.pc;
        end
        // An undefined op code from outside holds the counter where it is
        default: state_next.pc = state_reg.pc;
      endcase
    end

    // Writing the low byte also commits the buffered high bits
    if (pcl_wr) begin
      state_next.pc = {state_reg.program_counter_high_buffer[PCH_W-1:0], dat_wdata_i};
    end

    if (op_valid_i || dat_req_i) begin
      state_next.any_change = 1'b1;
    end

    // Preset code words stay flagged until software releases them
    if (rolling_release_i) begin
      state_next.roll_lock = 1'b0;
    end
    state_next.rolling_zone = state_next.roll_lock &&
      (state_next.pc == ROLL_LO || state_next.pc == ROLL_HI);
    // Only a warning: code in the top words is the user's fault, not trapped
    state_next.reserved_fetch = state_next.pc >= RSVD_LO;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= CORE_RST;
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Submodules
  mmb_stack u_stack (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .stk(stk_if.store)
  );

  mmb_gpr_ram u_gpr (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .ram(ram_if.store)
  );

  // ==========================================================
  // Outputs, all straight from state flops
  assign pc_o = state_reg.pc;
  assign status_o = state_reg.status;
  assign bank_sel_o = state_reg.status[BANK_MSB:BANK_LSB];
  assign dat_ack_o = state_reg.ack;
  assign dat_rdata_o = state_reg.rdata;
  assign timer_wr_o = state_reg.timer_wr;
  assign timer_wdata_o = state_reg.timer_wdata;
  assign aux_req_o = state_reg.aux_req;
  assign aux_page_b_o = state_reg.aux_page_b;
  assign aux_wr_o = state_reg.aux_wr;
  assign aux_addr_o = state_reg.aux_addr;
  assign aux_wdata_o = state_reg.aux_wdata;
  assign reserved_fetch_o = state_reg.reserved_fetch;
  assign rolling_zone_o = state_reg.rolling_zone;

  // ==========================================================
  // Checks
  a_reset_vector_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !state_reg.any_change |-> pc_o == RESET_VEC)
    else $error("program counter left the reset vector with no cause");

  a_soft_irq_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (clk_en_i && op_valid_i && op_kind_i == OP_SWI && !dat_req_i) |=> pc_o == SWI_VEC)
    else $error("software interrupt did not reach its vector");

  a_hard_irq_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (clk_en_i && op_valid_i && op_kind_i == OP_HWI && !dat_req_i) |=> pc_o == HWI_VEC)
    else $error("hardware interrupt did not reach the shared vector");

  a_short_jump_page: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (clk_en_i && op_valid_i && op_kind_i == OP_SJMP && !dat_req_i)
    |=> pc_o == {$past(pc_o[PC_W-1:SHORT_W]), $past(op_target_i[SHORT_W-1:0])})
    else $error("short jump disturbed the upper program counter bits");

  a_long_jump_full: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (clk_en_i && op_valid_i && op_kind_i == OP_LJMP && !dat_req_i)
    |=> pc_o == $past(op_target_i))
    else $error("long jump did not load the full target");

  a_call_then_return: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (clk_en_i && op_valid_i && op_kind_i == OP_LONG_CALL_INSTR && !dat_req_i)
    ##1 (clk_en_i && op_valid_i && op_kind_i == OP_RET && !dat_req_i)
    |=> pc_o == $past(pc_o, 2) + PC_W'(1))
    else $error("return did not resume after the call");

  a_status_any_bank: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (clk_en_i && dat_req_i && !dat_wr_i && dat_page_i == PG_R && dat_addr_i == ADDR_STATUS)
    ##1 clk_en_i |=> dat_ack_o && dat_rdata_o == $past(status_o, 2))
    else $error("status read did not alias from the active bank");

  a_unmapped_reads_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (clk_en_i && dat_req_i && dat_page_i == PG_R && mmb_region(dat_addr_i) == RG_NONE)
    ##1 clk_en_i |=> dat_ack_o && dat_rdata_o == '0)
    else $error("unassigned register did not read zero");

  a_aux_bank_free: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (clk_en_i && dat_req_i && dat_page_i != PG_R)
    |=> aux_req_o && aux_addr_o == $past(dat_addr_i[AUX_AW-1:0]) &&
        aux_page_b_o == ($past(dat_page_i) == PG_B))
    else $error("auxiliary access address or page wrong");

  a_pcl_loads_high: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (clk_en_i && dat_req_i && dat_wr_i && dat_page_i == PG_R && dat_addr_i == ADDR_PCL)
    |=> pc_o == {$past(state_reg.program_counter_high_buffer[PCH_W-1:0]), $past(dat_wdata_i)})
    else $error("low byte write did not take the buffered high bits");

  a_timer_write_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (clk_en_i && dat_req_i && dat_wr_i && dat_page_i == PG_R && dat_addr_i == ADDR_TIMER)
    |=> timer_wr_o && timer_wdata_o == $past(dat_wdata_i))
    else $error("timer write did not reach the far side");

  a_status_bank_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (clk_en_i && dat_req_i && dat_wr_i && dat_page_i == PG_R && dat_addr_i == ADDR_STATUS)
    |=> bank_sel_o == $past(dat_wdata_i[BANK_MSB:BANK_LSB]))
    else $error("status write did not set the bank bits");

  a_access_acked: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (clk_en_i && dat_req_i) ##1 clk_en_i |=> dat_ack_o)
    else $error("data access was not acknowledged");
endmodule
`default_nettype wire

// [mmb_far_model.sv]
// Behavioural model of the timer and auxiliary register pages outside the core
`timescale 1ns/1ps
`default_nettype none
module mmb_far_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic aux_req_i,
  input wire logic aux_page_b_i,
  input wire logic [4:0] aux_addr_i,
  input wire logic timer_wr_i,
  input wire logic [7:0] timer_wdata_i,
  output logic [7:0] aux_rdata_o,
  output logic [7:0] timer_count_o
);
  logic [7:0] pat_reg;
  // ==========================================================
  // Timer holds its value so reads are predictable; pattern runs free
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_count_o <= 8'h00;
      pat_reg <= 8'h00;
    end else begin
      pat_reg <= pat_reg + 8'h01;
      if (timer_wr_i) timer_count_o <= timer_wdata_i;
    end
  end
  // Data valid only while requested, otherwise a changing pattern
  assign aux_rdata_o = aux_req_i ? {aux_page_b_i, 2'b01, aux_addr_i} : pat_reg;
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the program-counter and data-banking core
`timescale 1ns/1ps
`default_nettype none
module tb import mmb_pkg::*; ;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  mmb_op_e op_kind = OP_STEP;
  logic [9:0] op_target = 10'h000;
  logic rel = 1'b0;
  logic req = 1'b0;
  logic wr = 1'b0;
  mmb_page_e page = PG_R;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] tcnt, ardata, rdata, twdata, awdata;
  logic [9:0] pc;
  logic [1:0] bank;
  logic ack, twr, areq, apb, rsv, rz, awr;
  logic ce = 1'b1;
  logic fwe = 1'b0;
  logic [2:0] flg = 3'h0;
  logic [7:0] stat;
  logic awr_seen = 1'b0;
  logic [7:0] awd_seen = 8'h00;
  logic [4:0] aaddr;
  int fails = 0;
  int compares = 0;
  int i;
  // ==========================================================
  // Clock, device and far-side model
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  mmb_core DUT (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .clk_en_i(ce), .op_valid_i(op_valid),
    .op_kind_i(op_kind), .op_target_i(op_target), .rolling_release_i(rel), .dat_req_i(req),
    .dat_wr_i(wr), .dat_page_i(page), .dat_addr_i(addr), .dat_wdata_i(wdata),
    .alu_flags_we_i(fwe), .alu_flags_i(flg), .timer_count_i(tcnt), .aux_rdata_i(ardata),
    .pc_o(pc), .status_o(stat), .bank_sel_o(bank), .dat_ack_o(ack), .dat_rdata_o(rdata),
    .timer_wr_o(twr), .timer_wdata_o(twdata), .aux_req_o(areq), .aux_page_b_o(apb),
    .aux_wr_o(awr), .aux_addr_o(aaddr), .aux_wdata_o(awdata), .reserved_fetch_o(rsv),
    .rolling_zone_o(rz));
  mmb_far_model far (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .aux_req_i(areq),
    .aux_page_b_i(apb), .aux_addr_i(aaddr), .timer_wr_i(twr), .timer_wdata_i(twdata),
    .aux_rdata_o(ardata), .timer_count_o(tcnt));
  // Latch what the core last offered on the auxiliary pages; the pulse is gone by compare time
  always @(posedge sys_clk) begin
    if (areq) begin
      awr_seen <= awr;
      awd_seen <= awdata;
    end
  end
  // ==========================================================
  // Compare and access tasks
  task automatic chk_pc(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_dat(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One program-flow op, then the new pc is compared
  task automatic op(input mmb_op_e k, input logic [9:0] t, input logic [9:0] exp);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_target <= t;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1 chk_pc(pc, exp);
  endtask
  // One data access; ack stands for one cycle, after the edge that follows the taken edge
  task automatic acc(input logic w, input mmb_page_e p, input logic [6:0] a,
      input logic [7:0] d, input logic [7:0] exp);
    @(posedge sys_clk);
    req <= 1'b1;
    wr <= w;
    page <= p;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    req <= 1'b0;
    @(posedge sys_clk);
    #1 chk_dat({7'h00, ack}, 8'h01);
    if (!w) chk_dat(rdata, exp);
  endtask
  task automatic close_out();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // Watchdog sized well past the expected run of about 140 cycles
  initial begin
    #200000;
    fails++;
    close_out();
  end
  // ==========================================================
  // Test sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 chk_pc(pc, 10'h000);
    chk_pc({8'h00, bank}, 10'h000);
    // Preset code words flag until released
    op(OP_LJMP, 10'h00e, 10'h00e);
    chk_pc({9'h000, rz}, 10'h001);
    @(posedge sys_clk);
    rel <= 1'b1;
    @(posedge sys_clk);
    rel <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk_pc({9'h000, rz}, 10'h000);
    // Branch reach, wrap of the ten-bit counter, vectors and all returns
    op(OP_LJMP, 10'h3ff, 10'h3ff);
    op(OP_STEP, 10'h000, 10'h000);
    op(OP_LJMP, 10'h3a5, 10'h3a5);
    op(OP_SJMP, 10'h012, 10'h312);
    op(OP_SCALL, 10'h040, 10'h340);
    op(OP_LONG_CALL_INSTR, 10'h3fe, 10'h3fe);
    chk_pc({9'h000, rsv}, 10'h001);
    op(OP_HWI, 10'h000, 10'h008);
    op(OP_RETURN_FROM_INTERRUPT_INSTR, 10'h000, 10'h3fe);
    op(OP_RETURN_WITH_LITERAL_INSTR, 10'h000, 10'h341);
    op(OP_RET, 10'h000, 10'h313);
    op(OP_SWI, 10'h000, 10'h001);
    op(OP_RET, 10'h000, 10'h313);
    // Fill all eight stack levels, then unwind
    op(OP_LJMP, 10'h100, 10'h100);
    for (i = 0; i < 8; i++) op(OP_LONG_CALL_INSTR, 10'(32'h200 + i * 16), 10'(32'h200 + i * 16));
    for (i = 7; i >= 0; i--) op(OP_RET, 10'h000, (i == 0) ? 10'h101 : 10'(32'h1f1 + i * 16));
    // Back-to-back calls and returns with no idle cycle between ops
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_kind <= OP_LONG_CALL_INSTR;
    op_target <= 10'h2c0;
    @(posedge sys_clk);
    op_target <= 10'h2d0;
    @(posedge sys_clk);
    op_kind <= OP_RET;
    #1 chk_pc(pc, 10'h2d0);
    @(posedge sys_clk);
    #1 chk_pc(pc, 10'h2c1);
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1 chk_pc(pc, 10'h102);
    // Banked storage, aliases, indirect port and unassigned places
    acc(1'b1, PG_R, 7'h25, 8'ha5, 8'h00);
    acc(1'b1, PG_R, 7'h03, 8'hc0, 8'h00);
    #1 chk_pc({8'h00, bank}, 10'h003);
    chk_dat(stat, 8'hc0);
    // Arithmetic flags land in the low bits and leave the bank bits alone
    @(posedge sys_clk);
    fwe <= 1'b1;
    flg <= 3'h5;
    @(posedge sys_clk);
    fwe <= 1'b0;
    #1 chk_dat(stat, 8'hc5);
    acc(1'b0, PG_R, 7'h03, 8'h00, 8'hc5);
    acc(1'b0, PG_R, 7'h25, 8'h00, 8'ha5);
    acc(1'b1, PG_R, 7'h04, 8'ha5, 8'h00);
    acc(1'b0, PG_R, 7'h04, 8'h00, 8'ha5);
    acc(1'b0, PG_R, 7'h00, 8'h00, 8'ha5);
    acc(1'b1, PG_R, 7'h60, 8'h77, 8'h00);
    acc(1'b0, PG_R, 7'h60, 8'h00, 8'h00);
    acc(1'b0, PG_R, 7'h05, 8'h00, 8'h00);
    acc(1'b1, PG_R, 7'h01, 8'h5a, 8'h00);
    acc(1'b0, PG_R, 7'h01, 8'h00, 8'h5a);
    acc(1'b1, PG_R, 7'h0a, 8'h03, 8'h00);
    acc(1'b0, PG_R, 7'h0a, 8'h00, 8'h03);
    acc(1'b1, PG_R, 7'h02, 8'h44, 8'h00);
    chk_pc(pc, 10'h344);
    // Clock enable low freezes the counter while an op waits
    @(posedge sys_clk);
    ce <= 1'b0;
    op_valid <= 1'b1;
    op_kind <= OP_LJMP;
    op_target <= 10'h155;
    repeat (3) @(posedge sys_clk);
    #1 chk_pc(pc, 10'h344);
    @(posedge sys_clk);
    ce <= 1'b1;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1 chk_pc(pc, 10'h155);
    // Auxiliary write goes out with its data and write flag
    acc(1'b1, PG_A, 7'h0a, 8'h3c, 8'h00);
    chk_dat(awd_seen, 8'h3c);
    chk_dat({7'h00, awr_seen}, 8'h01);
    acc(1'b0, PG_B, 7'h13, 8'h00, 8'hb3);
    acc(1'b0, PG_A, 7'h06, 8'h00, 8'h26);
    chk_dat({7'h00, awr_seen}, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
